/* File: design/dps_status.sv */
// module: debug access status registers and system clock request
// What this block does
// RULE1 - writing clock request one keeps system clock requested during sleep
// RULE2 - writing clock request zero withdraws the system clock request
// RULE3 - clock request comes up set when the debug port becomes enabled
// RULE4 - wipe failed flag, bit 6, sets when a chip erase fails
// RULE5 - wipe failed flag clears on any reset, including held reset request
// RULE6 - reset active flag, bit 5, shows a system domain reset
// RULE7 - reading the status register clears the reset active flag
// RULE8 - sleeping flag, bit 4, is one in idle or deeper sleep
// RULE9 - nonvolatile write ready, bit 3, shows programming may start
// RULE10 - programmer resets the system via reset request after programming
// RULE11 - user row write ready, bit 2, shows user row programming may start
// RULE12 - programmer writes user row finished once data sits in RAM
// RULE13 - locked flag, bit 0, reads one when locked; status resets 0x01
// RULE14 - locked flag reads zero after erase has cleared lock bits
// RULE15 - checksum state is one-hot: off, running, good, failing
// RULE16 - signature 0x59 resets the system, 0x00 releases it
// RULE17 - user row finished starts flash copy, only after key accepted
`timescale 1ns/1ps
module dps_status
    import dps_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [3:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    output logic o_reg_rvalid,
    input wire logic i_sys_reset_active,
    input wire logic i_sys_sleeping,
    input wire logic i_nvm_ready,
    input wire logic i_urow_ready,
    input wire logic i_locked,
    input wire logic i_erase_failed,
    input wire logic i_port_enabled,
    input wire logic i_urow_key_ok,
    input wire logic [2:0] i_crc_state,
    output logic o_system_clock_request,
    output logic o_system_reset_request,
    output logic o_user_row_start
);
    dps_sync_if #(.W(DPS_SYNC_W)) sy ();
    logic [DPS_SYNC_W-1:0] raw;
    assign raw = {i_crc_state, i_urow_key_ok, i_port_enabled, i_erase_failed,
                  i_locked, i_urow_ready, i_nvm_ready, i_sys_sleeping, i_sys_reset_active};

    dps_sync #(.W(DPS_SYNC_W), .RST(DPS_SYNC_RST)) u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_raw(raw),
        .o_sync(sy)
    );

    logic s_rst, s_sleep, s_nvm, s_urow, s_lock, s_wfail, s_en, s_ukey;
    logic [2:0] s_crc;
    assign s_rst = sy.synced[DPS_SY_RST];
    assign s_sleep = sy.synced[DPS_SY_SLEEP];
    assign s_nvm = sy.synced[DPS_SY_NVM];
    assign s_urow = sy.synced[DPS_SY_UROW];
    assign s_lock = sy.synced[DPS_SY_LOCK];
    assign s_wfail = sy.synced[DPS_SY_WFAIL];
    assign s_en = sy.synced[DPS_SY_EN];
    assign s_ukey = sy.synced[DPS_SY_UKEY];
    assign s_crc = sy.synced[DPS_SY_CRC +: 3];

    logic wr_ctrl, wr_rreq, rd_status;
    assign wr_ctrl = i_reg_wr && (i_reg_addr == DPS_OFF_SYS_CTRL);
    assign wr_rreq = i_reg_wr && (i_reg_addr == DPS_OFF_RESET_REQ);
    assign rd_status = i_reg_rd && (i_reg_addr == DPS_OFF_SYS_STATUS);

    // edge detectors read only the second synchroniser stage
    logic en_d_reg, wfail_d_reg;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            en_d_reg <= 1'b0;
            wfail_d_reg <= 1'b0;
        end else begin
            en_d_reg <= s_en;
            wfail_d_reg <= s_wfail;
        end
    end
    logic en_rise, wfail_rise;
    assign en_rise = s_en && !en_d_reg;
    assign wfail_rise = s_wfail && !wfail_d_reg;

    // reset request register: stays put across the system reset it causes
    logic [7:0] rreq_reg;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            rreq_reg <= DPS_RESET_REQ_RST;
        end else if (wr_rreq) begin
            rreq_reg <= i_reg_wdata;
        end
    end
    logic rreq_held;
    // RULE16 signature decode
    assign rreq_held = (rreq_reg == DPS_RESET_SIGNATURE);
    assign o_system_reset_request = rreq_held;

    // clock request: disabling the port lowers it
    logic system_clock_request_reg;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || !s_en) begin
            system_clock_request_reg <= 1'b0;
        end else if (wr_ctrl) begin
            // RULE1 RULE2 write sets or clears
            system_clock_request_reg <= i_reg_wdata[DPS_CTRL_SYSTEM_CLOCK_REQUEST_BIT];
        end else if (en_rise) begin
            // RULE3 set on enable
            system_clock_request_reg <= 1'b1;
        end
    end
    assign o_system_clock_request = system_clock_request_reg;

    // user row finished: ignored without the key, so no stray flash copy
    logic urow_done_reg, urow_start_reg;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            urow_done_reg <= DPS_SYS_CTRL_RST[DPS_CTRL_UROW_DONE_BIT];
            urow_start_reg <= 1'b0;
        end else begin
            urow_start_reg <= 1'b0;
            // RULE17 keyed start pulse
            if (wr_ctrl && s_ukey) begin
                urow_done_reg <= i_reg_wdata[DPS_CTRL_UROW_DONE_BIT];
                urow_start_reg <= i_reg_wdata[DPS_CTRL_UROW_DONE_BIT];
            end
        end
    end
    assign o_user_row_start = urow_start_reg;

    // wipe failed flag
    logic wfail_reg;
    always_ff @(posedge i_mclk) begin
        // RULE5 any reset clears
        if (!i_rst_n || s_rst || rreq_held) begin
            wfail_reg <= 1'b0;
        end else if (wfail_rise) begin
            // RULE4 erase failure sets
            wfail_reg <= 1'b1;
        end
    end

    // reset active flag: set wins over the read clear so no reset is missed
    logic system_reset_active_reg;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            system_reset_active_reg <= DPS_SYS_STATUS_RST[DPS_ST_SYSTEM_RESET_ACTIVE_BIT];
        end else if (s_rst || rreq_held) begin
            // RULE6 reset seen
            system_reset_active_reg <= 1'b1;
        end else if (rd_status) begin
            // RULE7 clear on read
            system_reset_active_reg <= 1'b0;
        end
    end

    // plain status levels sampled each cycle
    logic sleep_reg, nvm_reg, urow_reg, lock_reg;
    logic [2:0] crc_reg;
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            sleep_reg <= DPS_SYS_STATUS_RST[DPS_ST_SLEEP_BIT];
            nvm_reg <= DPS_SYS_STATUS_RST[DPS_ST_NVM_BIT];
            urow_reg <= DPS_SYS_STATUS_RST[DPS_ST_UROW_BIT];
            // RULE13 locked out of reset
            lock_reg <= DPS_SYS_STATUS_RST[DPS_ST_LOCK_BIT];
            crc_reg <= DPS_CRC_STATUS_RST[2:0];
        end else begin
            // RULE8 sleep level
            sleep_reg <= s_sleep;
            // RULE9 nvm ready
            nvm_reg <= s_nvm;
            // RULE11 user row ready
            urow_reg <= s_urow;
            // RULE14 follows lock bits
            lock_reg <= s_lock;
            // RULE15 one-hot checksum state
            crc_reg <= s_crc;
        end
    end

    logic [7:0] status_val;
    always_comb begin
        status_val = 8'h00;
        status_val[DPS_ST_WIPEFAIL_BIT] = wfail_reg;
        status_val[DPS_ST_SYSTEM_RESET_ACTIVE_BIT] = system_reset_active_reg;
        status_val[DPS_ST_SLEEP_BIT] = sleep_reg;
        status_val[DPS_ST_NVM_BIT] = nvm_reg;
        status_val[DPS_ST_UROW_BIT] = urow_reg;
        status_val[DPS_ST_LOCK_BIT] = lock_reg;
    end

    // read data registered one cycle after the strobe
    logic [7:0] rdata_next;
    always_comb begin
        unique case (i_reg_addr)
            DPS_OFF_RESET_REQ: rdata_next = rreq_reg;
            DPS_OFF_SYS_CTRL: rdata_next = {6'h0, urow_done_reg, system_clock_request_reg};
            DPS_OFF_SYS_STATUS: rdata_next = status_val;
            DPS_OFF_CRC_STATUS: rdata_next = {5'h0, crc_reg};
            default: rdata_next = 8'h00;
        endcase
    end
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_reg_rdata <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= rdata_next;
            end
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    system_clock_request_write_one_a: assert property ( // RULE1
        wr_ctrl && i_reg_wdata[DPS_CTRL_SYSTEM_CLOCK_REQUEST_BIT] && s_en ##1 s_en |-> o_system_clock_request)
        else $error("clock request not set by write");
    system_clock_request_write_zero_a: assert property ( // RULE2
        wr_ctrl && !i_reg_wdata[DPS_CTRL_SYSTEM_CLOCK_REQUEST_BIT] |=> !o_system_clock_request)
        else $error("clock request not withdrawn");
    system_clock_request_enable_a: assert property ( // RULE3
        $rose(s_en) && !wr_ctrl ##1 s_en |-> o_system_clock_request)
        else $error("clock request not raised on enable");
    wipe_fail_set_a: assert property ( // RULE4
        wfail_rise && !s_rst && !rreq_held |=> status_val[DPS_ST_WIPEFAIL_BIT])
        else $error("wipe failed flag not set");
    wipe_fail_clear_a: assert property ( // RULE5
        s_rst || rreq_held |=> !status_val[DPS_ST_WIPEFAIL_BIT])
        else $error("wipe failed flag survived reset");
    system_reset_active_set_a: assert property ( // RULE6
        s_rst |=> status_val[DPS_ST_SYSTEM_RESET_ACTIVE_BIT])
        else $error("reset active flag missing");
    system_reset_active_read_clear_a: assert property ( // RULE7
        rd_status && !s_rst && !rreq_held |=> !status_val[DPS_ST_SYSTEM_RESET_ACTIVE_BIT])
        else $error("reset active flag not cleared by read");
    sleep_follow_a: assert property ( // RULE8
        s_sleep [*2] |-> status_val[DPS_ST_SLEEP_BIT])
        else $error("sleep flag does not follow");
    reset_sig_a: assert property ( // RULE16
        wr_rreq && i_reg_wdata == DPS_RESET_RUN |=> !o_system_reset_request)
        else $error("reset not released by zero");
    urow_key_a: assert property ( // RULE17
        o_user_row_start |-> $past(s_ukey) && $past(wr_ctrl))
        else $error("user row start without key");

    cov_enable_c: cover property ($rose(o_system_clock_request));
    cov_reset_c: cover property (o_system_reset_request ##[1:20] !o_system_reset_request);
    cov_rdclr_c: cover property (system_reset_active_reg && rd_status ##1 !system_reset_active_reg);
    cov_urow_c: cover property (o_user_row_start);
endmodule

/* File: design/dps_pkg.sv */
// package: register map, field positions and codes of the debug status block
package dps_pkg;
    localparam logic [3:0] DPS_OFF_RESET_REQ = 4'h8;
    localparam logic [3:0] DPS_OFF_SYS_CTRL = 4'hA;
    localparam logic [3:0] DPS_OFF_SYS_STATUS = 4'hB;
    localparam logic [3:0] DPS_OFF_CRC_STATUS = 4'hC;
    localparam int DPS_CTRL_SYSTEM_CLOCK_REQUEST_BIT = 0;
    localparam int DPS_CTRL_UROW_DONE_BIT = 1;
    localparam int DPS_ST_LOCK_BIT = 0;
    localparam int DPS_ST_UROW_BIT = 2;
    localparam int DPS_ST_NVM_BIT = 3;
    localparam int DPS_ST_SLEEP_BIT = 4;
    localparam int DPS_ST_SYSTEM_RESET_ACTIVE_BIT = 5;
    localparam int DPS_ST_WIPEFAIL_BIT = 6;
    localparam logic [7:0] DPS_RESET_REQ_RST = 8'h00;
    localparam logic [7:0] DPS_SYS_CTRL_RST = 8'h00;
    localparam logic [7:0] DPS_SYS_STATUS_RST = 8'h01;
    localparam logic [7:0] DPS_CRC_STATUS_RST = 8'h00;
    localparam logic [7:0] DPS_RESET_SIGNATURE = 8'h59;
    localparam logic [7:0] DPS_RESET_RUN = 8'h00;
    localparam logic [2:0] DPS_CRC_OFF = 3'h0;
    localparam logic [2:0] DPS_CRC_BUSY = 3'h1;
    localparam logic [2:0] DPS_CRC_GOOD = 3'h2;
    localparam logic [2:0] DPS_CRC_FAIL = 3'h4;
    // index of each system-side level in the synchronised vector
    localparam int DPS_SY_RST = 0;
    localparam int DPS_SY_SLEEP = 1;
    localparam int DPS_SY_NVM = 2;
    localparam int DPS_SY_UROW = 3;
    localparam int DPS_SY_LOCK = 4;
    localparam int DPS_SY_WFAIL = 5;
    localparam int DPS_SY_EN = 6;
    localparam int DPS_SY_UKEY = 7;
    localparam int DPS_SY_CRC = 8;
    localparam int DPS_SYNC_W = 11;
    // lock level idles high so the locked flag does not dip after reset
    localparam logic [DPS_SYNC_W-1:0] DPS_SYNC_RST = 11'h010;
endpackage

/* File: design/dps_sync_if.sv */
// interface: synchronised system-side levels passed to the status logic
`timescale 1ns/1ps
interface dps_sync_if #(parameter int W = 11);
    logic [W-1:0] synced;
    modport src (output synced);
    modport sink (input synced);
endinterface

/* File: design/dps_sync.sv */
// module: two-flop synchroniser bank for system-side levels
`timescale 1ns/1ps
module dps_sync #(parameter int W = 11, parameter logic [W-1:0] RST = '0) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [W-1:0] i_raw,
    dps_sync_if.src o_sync
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            // first stage feeds only the second stage
            always_ff @(posedge i_mclk) begin
                if (!i_rst_n) begin
                    meta_reg[g] <= RST[g];
                    sync_reg[g] <= RST[g];
                end else begin
                    meta_reg[g] <= i_raw[g];
                    sync_reg[g] <= meta_reg[g];
                end
            end
        end
    endgenerate
    assign o_sync.synced = sync_reg;
endmodule

/* File: tb/dps_programmer.sv */
// programmer model driving the register port of the status block
`timescale 1ns/1ps
module dps_programmer
    import dps_pkg::*;
(
    input wire logic i_mclk,
    input wire logic [7:0] i_rdata,
    input wire logic i_rvalid,
    output logic [3:0] o_addr,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata
);
    initial begin
        o_addr = 4'h0;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        o_addr = a;
        o_wdata = d;
        o_wr = 1'b1;
        @(negedge i_mclk);
        o_wr = 1'b0;
        // released lines show the inverse, never the last value
        o_addr = ~a;
        o_wdata = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic v);
        @(negedge i_mclk);
        o_addr = a;
        o_rd = 1'b1;
        @(negedge i_mclk);
        o_rd = 1'b0;
        o_addr = ~a;
        d = i_rdata;
        v = i_rvalid;
    endtask
    task automatic nvm_done();
        wr(DPS_OFF_RESET_REQ, DPS_RESET_SIGNATURE);
    endtask
    // user row finished, clock request kept
    task automatic urow_done();
        wr(DPS_OFF_SYS_CTRL, 8'h03);
    endtask
endmodule

/* File: tb/dps_status_tb_top.sv */
// self-checking bench of the debug status block
`timescale 1ns/1ps
module dps_status_tb_top
    import dps_pkg::*;
;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rvalid;
    logic clk_req;
    logic rst_req;
    logic urow_start;
    logic s_rst = 1'b0;
    logic s_sleep = 1'b0;
    logic s_nvm = 1'b0;
    logic s_urow = 1'b0;
    logic s_lock = 1'b1;
    logic s_wfail = 1'b0;
    logic s_en = 1'b0;
    logic s_key = 1'b0;
    logic [2:0] s_crc = 3'h0;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    int starts = 0;
    // rows: {crc, lock, urow, nvm, sleep} and {status, checksum}
    logic [6:0] tin [6] = '{7'h01, 7'h12, 7'h24, 7'h48, 7'h00, 7'h39};
    logic [15:0] texp [6] = '{16'h1000, 16'h0801, 16'h0402, 16'h0104, 16'h0000, 16'h1103};
    always #2.5 mclk = ~mclk;
    dps_status i_dps_status (.i_mclk(mclk), .i_rst_n(rst_n), .i_reg_addr(addr),
        .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_sys_reset_active(s_rst), .i_sys_sleeping(s_sleep),
        .i_nvm_ready(s_nvm), .i_urow_ready(s_urow), .i_locked(s_lock),
        .i_erase_failed(s_wfail), .i_port_enabled(s_en), .i_urow_key_ok(s_key),
        .i_crc_state(s_crc), .o_system_clock_request(clk_req),
        .o_system_reset_request(rst_req), .o_user_row_start(urow_start));
    dps_programmer i_dps_programmer (.i_mclk(mclk), .i_rdata(rdata), .i_rvalid(rvalid),
        .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
    task automatic end_sim();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ceiling well above the roughly 160 cycles the run needs
    always @(posedge mclk) begin
        cycles++;
        if (urow_start === 1'b1) begin
            starts++;
        end
        if (cycles == 4000) begin
            miscompares++;
            end_sim();
        end
    end
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] e);
        logic [7:0] d;
        logic v;
        i_dps_programmer.rd(a, d, v);
        chk({n, " valid"}, 8'h01, {7'h00, v});
        chk(n, e, d);
    endtask
    // status inputs cross two sync flops and a register
    task automatic settle();
        repeat (4) @(negedge mclk);
    endtask
    initial begin
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        chk("clock request off", 8'h00, {7'h00, clk_req});
        rchk("status reset", DPS_OFF_SYS_STATUS, DPS_SYS_STATUS_RST);
        rchk("checksum reset", DPS_OFF_CRC_STATUS, DPS_CRC_STATUS_RST);
        rchk("unmapped", 4'h3, 8'h00);
        for (int i = 0; i < 6; i++) begin
            @(negedge mclk);
            {s_crc, s_lock, s_urow, s_nvm, s_sleep} = tin[i];
            settle();
            rchk("status", DPS_OFF_SYS_STATUS, texp[i][15:8]);
            rchk("checksum", DPS_OFF_CRC_STATUS, texp[i][7:0]);
        end
        s_en = 1'b1;
        settle();
        chk("clock request up", 8'h01, {7'h00, clk_req});
        i_dps_programmer.wr(DPS_OFF_SYS_CTRL, 8'h00);
        @(negedge mclk);
        chk("clock request down", 8'h00, {7'h00, clk_req});
        i_dps_programmer.wr(DPS_OFF_SYS_CTRL, 8'h01);
        settle();
        chk("clock request asleep", 8'h01, {7'h00, clk_req});
        s_wfail = 1'b1;
        settle();
        rchk("wipe failed set", DPS_OFF_SYS_STATUS, 8'h51);
        i_dps_programmer.nvm_done();
        @(negedge mclk);
        chk("reset request", 8'h01, {7'h00, rst_req});
        settle();
        rchk("held reset", DPS_OFF_SYS_STATUS, 8'h31);
        rchk("held reset again", DPS_OFF_SYS_STATUS, 8'h31);
        s_wfail = 1'b0;
        i_dps_programmer.wr(DPS_OFF_RESET_REQ, DPS_RESET_RUN);
        @(negedge mclk);
        chk("reset released", 8'h00, {7'h00, rst_req});
        settle();
        rchk("reset seen", DPS_OFF_SYS_STATUS, 8'h31);
        rchk("reset read clear", DPS_OFF_SYS_STATUS, 8'h11);
        i_dps_programmer.urow_done();
        settle();
        chk("start refused", 8'h00, 8'(starts));
        rchk("ctrl refused", DPS_OFF_SYS_CTRL, 8'h01);
        s_key = 1'b1;
        settle();
        i_dps_programmer.urow_done();
        settle();
        chk("start count", 8'h01, 8'(starts));
        rchk("ctrl done", DPS_OFF_SYS_CTRL, 8'h03);
        s_wfail = 1'b1;
        settle();
        rchk("wipe failed again", DPS_OFF_SYS_STATUS, 8'h51);
        s_rst = 1'b1;
        settle();
        rchk("system reset", DPS_OFF_SYS_STATUS, 8'h31);
        s_rst = 1'b0;
        s_wfail = 1'b0;
        settle();
        rchk("system reset seen", DPS_OFF_SYS_STATUS, 8'h31);
        rchk("system reset cleared", DPS_OFF_SYS_STATUS, 8'h11);
        // block reset in mid-run must clear a set wipe failed flag
        s_wfail = 1'b1;
        settle();
        s_wfail = 1'b0;
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        settle();
        chk("clock request after reset", 8'h01, {7'h00, clk_req});
        chk("reset request after reset", 8'h00, {7'h00, rst_req});
        rchk("status after reset", DPS_OFF_SYS_STATUS, 8'h11);
        rchk("ctrl after reset", DPS_OFF_SYS_CTRL, 8'h01);
        end_sim();
    end
endmodule
